// ### rtl/tce_pkg.sv
// Shared constants, register map and types of the trigger conditioning block
package tce_pkg;

	// Register byte offsets on the APB slave
	localparam int unsigned ADDR_W     = 8;
	localparam logic [7:0]  ADR_CTRL   = 8'h00;
	localparam logic [7:0]  ADR_FUNC   = 8'h04;
	localparam logic [7:0]  ADR_FILT   = 8'h08;
	localparam logic [7:0]  ADR_DIV    = 8'h0C;
	localparam logic [7:0]  ADR_EXPT   = 8'h10;
	localparam logic [7:0]  ADR_SWTRIG = 8'h14;
	localparam logic [7:0]  ADR_STATUS = 8'h18;

	// Field widths
	localparam int unsigned FILT_W = 24;
	localparam int unsigned DIV_W  = 4;
	localparam int unsigned EXPT_W = 32;
	localparam int unsigned CTRL_W = 12;
	localparam int unsigned FUNC_W = 3;
	localparam int unsigned STAT_W = 4;

	// Timing: system clock, filter tick and fixed start delay
	localparam int unsigned SYS_CLK_NS      = 20;
	localparam int unsigned FILT_TICK_NS    = 15;
	localparam int unsigned START_DELAY_NS  = 100;
	localparam int unsigned START_DELAY_CYC =
		(START_DELAY_NS + SYS_CLK_NS - 1) / SYS_CLK_NS;

	// Boolean function codes
	typedef enum logic [2:0] {
		FN_OFF, FN_AND, FN_NAND, FN_OR, FN_NOR, FN_XOR, FN_XNOR, FN_TRIG_EN
	} tce_func_type;

	// Control register layout, bit 11 down to bit 0
	typedef struct packed {
		logic [2:0] a_sel;      // First operand: 0..3 line, 4+ logic port
		logic [2:0] b_sel;      // Second operand: 0..3 line, 4+ logic port
		logic [1:0] src_line;   // Line used when logic unit not routed
		logic       use_logic;  // Route logic result as trigger source
		logic       filt_en;    // Insert debouncer
		logic       div_en;     // Insert prescaler
		logic       width_mode; // Exposure follows trigger pulse width
	} tce_ctrl_type;

	// Status register layout, bit 3 down to bit 0
	typedef struct packed {
		logic filt_lvl;
		logic cond_lvl;
		logic waiting;
		logic exposing;
	} tce_status_type;

	// Reset values
	localparam tce_ctrl_type CTRL_RST = '{a_sel: 3'h0, b_sel: 3'h1,
		src_line: 2'h0, use_logic: 1'h0, filt_en: 1'h0, div_en: 1'h0,
		width_mode: 1'h0};
	localparam logic [FILT_W-1:0] FILT_RST = 24'h01_046A;
	localparam logic [DIV_W-1:0]  DIV_RST  = 4'h2;
	localparam logic [EXPT_W-1:0] EXPT_RST = 32'h0000_03E8;

endpackage

// ### rtl/tce_debounce.sv
// Glitch filter: passes a level only after it held for the set length
`timescale 1ns/1ns
`default_nettype none
module tce_debounce
	import tce_pkg::*;
#(
	parameter int unsigned W = FILT_W
)
(
	input  wire logic         pclk,     // System clock
	input  wire logic         presetn,  // Async reset, active low
	input  wire logic         raw,      // Unfiltered level
	input  wire logic [W-1:0] len,      // Required stable cycles
	output logic              filt_q    // Accepted level
);
	logic [W-1:0] cnt_q;
	logic         raw_q;

	initial
	begin
		if (W < 2 || W > 32)
			$error("tce_debounce: W out of range");
	end

	// Stability counter, restarted by any change of the raw level
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			cnt_q  <= '0;
			raw_q  <= 1'b0;
			filt_q <= 1'b0;
		end
		else
		begin
			raw_q <= raw;
			if (raw != raw_q)
				cnt_q <= '0;
			else if (raw != filt_q)
			begin
				if (cnt_q + 1'b1 >= len)
				begin
					filt_q <= raw;
					cnt_q  <= '0;
				end
				else
					cnt_q <= cnt_q + 1'b1;
			end
			else
				cnt_q <= '0;
		end
	end

	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);

	chk_filt_hold: assert property ($changed(filt_q) |->
		$past(raw) == filt_q && $past(raw_q) == filt_q &&
		$past(cnt_q) + 1'b1 >= $past(len))
		else $error("filtered level changed before hold time");
endmodule
`default_nettype wire

// ### rtl/tce_prescale.sv
// Prescaler: passes one trigger pulse out of each group of ratio pulses
`timescale 1ns/1ns
`default_nettype none
module tce_prescale
	import tce_pkg::*;
#(
	parameter int unsigned W = DIV_W
)
(
	input  wire logic         pclk,     // System clock
	input  wire logic         presetn,  // Async reset, active low
	input  wire logic         clr,      // Divisor written, restart
	input  wire logic         pulse,    // One-cycle trigger in
	input  wire logic [W-1:0] ratio,    // Divisor, zero means 2**W
	output logic              out_q     // One-cycle trigger out
);
	logic [W-1:0] cnt_q;
	logic [W-1:0] last;

	initial
	begin
		if (W < 1 || W > 8)
			$error("tce_prescale: W out of range");
	end

	// Last count of a group; wraps so that zero selects the largest ratio
	assign last = ratio - 1'b1;

	// Pulse counter, masks all but the last pulse of a group
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			cnt_q <= '0;
			out_q <= 1'b0;
		end
		else
		begin
			out_q <= 1'b0;
			if (clr)
				cnt_q <= '0;
			else if (pulse)
			begin
				if (cnt_q == last)
				begin
					cnt_q <= '0;
					out_q <= 1'b1;
				end
				else
					cnt_q <= cnt_q + 1'b1;
			end
		end
	end

	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);

	chk_div_pass: assert property (out_q |->
		$past(pulse) && !$past(clr) && $past(cnt_q) == $past(last))
		else $error("prescaler passed a masked pulse");
	chk_div_clear: assert property (clr |=> cnt_q == '0)
		else $error("prescaler counter not cleared");
endmodule
`default_nettype wire

// ### rtl/tce_top.sv
// Trigger conditioning and exposure start with APB register access
// How it works
// - Logic unit always uses two operands
// - AND NAND OR NOR XOR XNOR, or off
// - Trigger enable: second gates the first
// - Accept level after stable programmed time
// - Filter length counted in system clock periods
// - Debouncer insertable, bypassed when disabled
// - Four-bit divisor, largest ratio sixteen
// - Prescaler passes one of divisor pulses
// - Reset trigger source is first input line
// - Rising trigger edge begins an exposure
// - Programmed mode ends after programmed time
// - Width mode follows trigger pulse width
// - Trigger during frame waits line-valid fall
// - Trigger outside frame starts after fixed delay
// - Exposure change applies only between exposures
// - Software command also starts an exposure
//
// The implementer's own choices: the APB slave port and the address map.
`timescale 1ns/1ns
`default_nettype none
module tce_top
	import tce_pkg::*;
#(
	parameter int unsigned LINES = 4
)
(
	input  wire logic              pclk,                 // System clock
	input  wire logic              presetn,              // Async reset
	input  wire logic              psel,                 // APB select
	input  wire logic              penable,              // APB enable
	input  wire logic              pwrite,               // APB direction
	input  wire logic [ADDR_W-1:0] paddr,                // APB address
	input  wire logic [31:0]       pwdata,               // APB write data
	output logic [31:0]            prdata_q,             // APB read data
	output logic                   pready_q,             // APB ready
	output logic                   pslverr_q,            // APB error
	input  wire logic [LINES-1:0]  trig_lines,           // Physical inputs
	input  wire logic              first_logic_operand,  // Chained logic A
	input  wire logic              second_logic_operand, // Chained logic B
	input  wire logic              frame_valid,          // Sensor readout
	input  wire logic              line_valid,           // Sensor line
	output logic                   logic_out_q,          // Logic result
	output logic                   exposure_q,           // Exposure active
	output logic                   expo_start_q          // Exposure begins
);
	localparam int START_WAIT = START_DELAY_CYC + 1; // Event edge to pulse

	typedef enum logic [1:0] {S_IDLE, S_WAIT_LV, S_DELAY, S_EXPOSE}
		tce_state_type;

	tce_ctrl_type      ctrl_q;
	tce_func_type      func_q;
	logic [FILT_W-1:0] filt_len_q;
	logic [DIV_W-1:0]  div_q;
	logic [EXPT_W-1:0] expt_q;
	logic [EXPT_W-1:0] exp_work_q;
	logic [EXPT_W-1:0] exp_cnt_q;
	logic [7:0]        dly_cnt_q;
	logic              sw_trig_q;
	logic              div_clr_q;
	logic              cond_q;
	logic              lv_q;
	tce_state_type     state_q;
	tce_status_type    status;

	logic        first_input_operand;
	logic        second_input_operand;
	logic        op_a;
	logic        op_b;
	logic        logic_y;
	logic        src_lvl;
	logic        filt_lvl;
	logic        cond_lvl;
	logic        cond_rise;
	logic        div_pulse;
	logic        hw_evt;
	logic        trig_evt;
	logic        lv_fall;
	logic        acc;
	logic        bus_wr;
	logic        hit;
	logic [31:0] rd_mux;

	initial
	begin
		if (LINES != 4)
			$error("tce_top: operand selects serve exactly four lines");
	end

	// Operand selection: a physical line or a chained logic result
	always_comb
	begin
		first_input_operand  = trig_lines[ctrl_q.a_sel[1:0]];
		second_input_operand = trig_lines[ctrl_q.b_sel[1:0]];
		op_a = ctrl_q.a_sel[2] ? first_logic_operand : first_input_operand;
		op_b = ctrl_q.b_sel[2] ? second_logic_operand
			: second_input_operand;
	end

	// Boolean function of the two operands
	always_comb
	begin
		unique case (func_q)
			FN_OFF:     logic_y = 1'b0;
			FN_AND:     logic_y = op_a & op_b;
			FN_NAND:    logic_y = ~(op_a & op_b);
			FN_OR:      logic_y = op_a | op_b;
			FN_NOR:     logic_y = ~(op_a | op_b);
			FN_XOR:     logic_y = op_a ^ op_b;
			FN_XNOR:    logic_y = ~(op_a ^ op_b);
			FN_TRIG_EN: logic_y = op_b & op_a;
		endcase
	end

	// Registered logic result, also offered as the trigger source
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			logic_out_q <= 1'b0;
		else
			logic_out_q <= logic_y;
	end

	// Source line, or logic result when routed
	assign src_lvl = ctrl_q.use_logic ? logic_out_q
		: trig_lines[ctrl_q.src_line];

	// Glitch filter, length in system clock periods
	tce_debounce #(.W(FILT_W)) u_filt
	(
		.pclk    (pclk),
		.presetn (presetn),
		.raw     (src_lvl),
		.len     (filt_len_q),
		.filt_q  (filt_lvl)
	);

	// Debouncer insertion point and edge detection
	assign cond_lvl  = ctrl_q.filt_en ? filt_lvl : src_lvl;
	assign cond_rise = cond_lvl & ~cond_q;

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			cond_q <= 1'b0;
			lv_q   <= 1'b0;
		end
		else
		begin
			cond_q <= cond_lvl;
			lv_q   <= line_valid;
		end
	end

	assign lv_fall = lv_q & ~line_valid;

	// Trigger divider
	tce_prescale #(.W(DIV_W)) u_div
	(
		.pclk    (pclk),
		.presetn (presetn),
		.clr     (div_clr_q),
		.pulse   (cond_rise),
		.ratio   (div_q),
		.out_q   (div_pulse)
	);

	// Hardware event on rising edge, optionally thinned by the divider
	assign hw_evt   = ctrl_q.div_en ? div_pulse : cond_rise;
	assign trig_evt = hw_evt | sw_trig_q;

	// Exposure sequencer
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			state_q      <= S_IDLE;
			dly_cnt_q    <= '0;
			exp_cnt_q    <= '0;
			exp_work_q   <= EXPT_RST;
			exposure_q   <= 1'b0;
			expo_start_q <= 1'b0;
		end
		else
		begin
			expo_start_q <= 1'b0;
			unique case (state_q)
				S_IDLE:
				begin
					dly_cnt_q <= '0;
					if (trig_evt)
					begin
						if (frame_valid)
							state_q <= S_WAIT_LV;
						else
							state_q <= S_DELAY;
					end
				end
				S_WAIT_LV:
				begin
					if (lv_fall)
					begin
						state_q      <= S_EXPOSE;
						exposure_q   <= 1'b1;
						expo_start_q <= 1'b1;
						exp_work_q   <= expt_q;
						exp_cnt_q    <= expt_q;
					end
				end
				S_DELAY:
				begin
					dly_cnt_q <= dly_cnt_q + 8'h01;
					if (dly_cnt_q == 8'(START_DELAY_CYC - 1))
					begin
						state_q      <= S_EXPOSE;
						exposure_q   <= 1'b1;
						expo_start_q <= 1'b1;
						exp_work_q   <= expt_q;
						exp_cnt_q    <= expt_q;
					end
				end
				S_EXPOSE:
				begin
					if (ctrl_q.width_mode)
					begin
						if (!cond_lvl)
						begin
							state_q    <= S_IDLE;
							exposure_q <= 1'b0;
						end
					end
					else if (exp_cnt_q <= 32'h0000_0001)
					begin
						state_q    <= S_IDLE;
						exposure_q <= 1'b0;
					end
					else
						exp_cnt_q <= exp_cnt_q - 32'h0000_0001;
				end
			endcase
		end
	end

	// APB access decode: one wait state, answer on the second access cycle
	assign acc    = psel & penable;
	assign bus_wr = acc & pready_q & pwrite;

	always_comb
	begin
		status.filt_lvl = filt_lvl;
		status.cond_lvl = cond_lvl;
		status.waiting  = (state_q == S_WAIT_LV) || (state_q == S_DELAY);
		status.exposing = exposure_q;
		hit    = 1'b1;
		rd_mux = '0;
		unique case (paddr)
			ADR_CTRL:   rd_mux[CTRL_W-1:0] = ctrl_q;
			ADR_FUNC:   rd_mux[FUNC_W-1:0] = func_q;
			ADR_FILT:   rd_mux[FILT_W-1:0] = filt_len_q;
			ADR_DIV:    rd_mux[DIV_W-1:0]  = div_q;
			ADR_EXPT:   rd_mux             = expt_q;
			ADR_SWTRIG: rd_mux             = '0;
			ADR_STATUS: rd_mux[STAT_W-1:0] = status;
			default:    hit                = 1'b0;
		endcase
	end

	// Bus handshake and read data
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			pready_q  <= 1'b0;
			pslverr_q <= 1'b0;
			prdata_q  <= '0;
		end
		else
		begin
			pready_q  <= acc & ~pready_q;
			pslverr_q <= acc & ~pready_q & ~hit;
			prdata_q  <= (acc & ~pready_q & ~pwrite) ? rd_mux : '0;
		end
	end

	// Configuration registers
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			ctrl_q     <= CTRL_RST;
			func_q     <= FN_OFF;
			filt_len_q <= FILT_RST;
			div_q      <= DIV_RST;
			expt_q     <= EXPT_RST;
		end
		else if (bus_wr)
		begin
			unique case (paddr)
				ADR_CTRL: ctrl_q     <= tce_ctrl_type'(pwdata[CTRL_W-1:0]);
				ADR_FUNC: func_q     <= tce_func_type'(pwdata[FUNC_W-1:0]);
				ADR_FILT: filt_len_q <= pwdata[FILT_W-1:0];
				ADR_DIV:  div_q      <= pwdata[DIV_W-1:0];
				ADR_EXPT: expt_q     <= pwdata;
				default:  ;
			endcase
		end
	end

	// Command strobes: software trigger and divider clear
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			sw_trig_q <= 1'b0;
			div_clr_q <= 1'b0;
		end
		else
		begin
			sw_trig_q <= bus_wr && paddr == ADR_SWTRIG && pwdata[0];
			div_clr_q <= bus_wr && paddr == ADR_DIV;
		end
	end

	// Helper: length of the running exposure
	logic [EXPT_W-1:0] hi_cnt_q;

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			hi_cnt_q <= '0;
		else if (expo_start_q)
			hi_cnt_q <= 32'h0000_0001;
		else if (exposure_q)
			hi_cnt_q <= hi_cnt_q + 32'h0000_0001;
	end

	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);

	chk_fv_wait: assert property (
		state_q == S_IDLE && trig_evt && frame_valid |=> state_q == S_WAIT_LV)
		else $error("trigger in frame did not wait for line fall");
	chk_lv_align: assert property (
		state_q == S_WAIT_LV && lv_fall |=> expo_start_q && exposure_q)
		else $error("exposure not started on line-valid fall");
	chk_lv_only: assert property (
		state_q == S_WAIT_LV && !lv_fall |=> !expo_start_q)
		else $error("exposure started without line-valid fall");
	chk_fixed_delay: assert property (
		state_q == S_IDLE && trig_evt && !frame_valid
		|-> ##START_WAIT expo_start_q)
		else $error("fixed start delay wrong");
	chk_prog_length: assert property (
		$fell(exposure_q) && !ctrl_q.width_mode && $past(exp_work_q) != '0
		|-> hi_cnt_q == $past(exp_work_q))
		else $error("programmed exposure length wrong");
	chk_width_end: assert property (
		state_q == S_EXPOSE && ctrl_q.width_mode && !cond_lvl
		|=> !exposure_q ##1 !exposure_q)
		else $error("pulse width exposure did not end");
	chk_shadow_hold: assert property (
		exposure_q && !expo_start_q |-> $stable(exp_work_q))
		else $error("exposure time changed mid exposure");
	chk_sw_start: assert property (
		state_q == S_IDLE && sw_trig_q && !frame_valid
		|-> ##[1:8] expo_start_q)
		else $error("software trigger did not start exposure");
	chk_apb_ready: assert property (
		acc && !pready_q |=> pready_q ##1 !pready_q)
		else $error("APB ready not a single pulse");

	cov_lv_align: cover property (state_q == S_WAIT_LV && lv_fall);
	cov_prog_exp: cover property ($fell(exposure_q) && !ctrl_q.width_mode);
	cov_width_exp: cover property ($fell(exposure_q) && ctrl_q.width_mode);
	cov_sw_trig: cover property (sw_trig_q && state_q == S_IDLE);
endmodule
`default_nettype wire

// ### test/tce_sensor_model.sv
// Sensor readout model driving frame-valid and line-valid levels
`timescale 1ns/1ns
`default_nettype none
module tce_sensor_model
(
	input  wire logic pclk,        // System clock
	input  wire logic presetn,     // Async reset, active low
	input  wire logic run,         // Frame readout in progress
	output var logic  frame_valid, // Frame valid level
	output var logic  line_valid   // Line valid level
);
	logic [2:0] phase_q;

	// Line phase: four cycles valid, three cycles blank
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			phase_q <= 3'h0;
		else if (!run || phase_q == 3'h6)
			phase_q <= 3'h0;
		else
			phase_q <= phase_q + 3'h1;
	end

	// Levels follow the registered phase, so they move after the edge
	always_comb
	begin
		frame_valid = run;
		line_valid  = run && (phase_q < 3'h4);
	end
endmodule
`default_nettype wire

// ### test/testbench.sv
// Self-checking bench for the trigger conditioning block
`timescale 1ns/1ns
`default_nettype none
module testbench
	import tce_pkg::*;
;
	logic         pclk, presetn, psel, penable, pwrite, run, err;
	logic [7:0]   paddr;
	logic [31:0]  pwdata, prdata_q, rd;
	logic         pready_q, pslverr_q, opa, opb;
	logic [3:0]   trig_lines;
	logic         frame_valid, line_valid;
	logic         logic_out_q, exposure_q, expo_start_q;
	logic [1:0]   lvh, lv_at;
	tce_ctrl_type c;
	int           bad_count, num_checks, d, l, d1, l1, s0;
	int           starts = 0;

	tce_top #(.LINES(4)) uut (.pclk(pclk), .presetn(presetn), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr),
		.pwdata(pwdata), .prdata_q(prdata_q), .pready_q(pready_q),
		.pslverr_q(pslverr_q), .trig_lines(trig_lines),
		.first_logic_operand(opa), .second_logic_operand(opb),
		.frame_valid(frame_valid), .line_valid(line_valid),
		.logic_out_q(logic_out_q), .exposure_q(exposure_q),
		.expo_start_q(expo_start_q));

	tce_sensor_model sensor (.pclk(pclk), .presetn(presetn), .run(run),
		.frame_valid(frame_valid), .line_valid(line_valid));

	// Clock and observation history
	initial
	begin
		pclk = 1'b0;
		forever #10 pclk = ~pclk;
	end
	always @(posedge pclk) lvh <= {lvh[0], line_valid};
	always @(posedge pclk) if (expo_start_q === 1'b1) starts <= starts + 1;

	task chk(input logic [31:0] got, input logic [31:0] exp);
		num_checks++;
		if (got !== exp)
		begin
			bad_count++;
			$display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
		end
	endtask

	task finish_test;
		if (bad_count == 0 && num_checks > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask

	task tmo;
		bad_count++;
		$display("CHECK FAILED at %0t: wait ran out", $time);
		finish_test;
	endtask

	task cyc(input int n);
		repeat (n) @(posedge pclk);
	endtask

	// One APB transfer: setup, access until ready, then one idle edge
	task apb(input logic w, input logic [7:0] a, input logic [31:0] dw);
		int n;
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= a;
		pwdata <= dw;
		@(posedge pclk);
		penable <= 1'b1;
		n = 0;
		do
		begin
			@(posedge pclk);
			n++;
			if (n > 20) tmo;
		end while (pready_q !== 1'b1);
		rd = prdata_q;
		err = pslverr_q;
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge pclk);
	endtask

	task pulse(input int hi, input int lo);
		trig_lines[0] <= 1'b1;
		cyc(hi);
		trig_lines[0] <= 1'b0;
		cyc(lo);
	endtask

	// Edges to exposure start, then cycles with exposure high
	task expo;
		d = 0;
		l = 0;
		while (expo_start_q !== 1'b1)
		begin
			@(posedge pclk);
			d++;
			if (d > 400) tmo;
		end
		lv_at = lvh;
		while (exposure_q === 1'b1)
		begin
			@(posedge pclk);
			l++;
			if (l > 400) tmo;
		end
	endtask

	function automatic logic lexp(input int f, input logic a, input logic b);
		case (f)
			1: return a & b;
			2: return ~(a & b);
			3: return a | b;
			4: return ~(a | b);
			5: return a ^ b;
			6: return ~(a ^ b);
			7: return a & b;
			default: return 1'b0;
		endcase
	endfunction

	initial
	begin
		{presetn, psel, penable, pwrite, run, opa, opb} = 7'h00;
		paddr = 8'h00;
		pwdata = 32'h0000_0000;
		trig_lines = 4'h0;
		repeat (8) @(posedge pclk);
		presetn <= 1'b1;
		@(posedge pclk);
		// Reset values and an unmapped address
		apb(1'b0, ADR_CTRL, 32'h0);
		chk(rd, {20'h0, CTRL_RST});
		apb(1'b0, ADR_FUNC, 32'h0);
		chk(rd, 32'h0000_0000);
		apb(1'b0, ADR_FILT, 32'h0);
		chk(rd, {8'h00, FILT_RST});
		apb(1'b0, ADR_DIV, 32'h0);
		chk(rd, {28'h0, DIV_RST});
		apb(1'b0, ADR_EXPT, 32'h0);
		chk(rd, EXPT_RST);
		apb(1'b0, 8'h1C, 32'h0);
		chk({rd[30:0], err}, 32'h0000_0001);
		// Programmed exposure from the first line, change mid exposure
		apb(1'b1, ADR_EXPT, 32'h0000_0006);
		fork
			pulse(10, 2);
			expo;
			begin
				cyc(7);
				apb(1'b1, ADR_EXPT, 32'h0000_0009);
			end
		join
		d1 = d;
		chk(l, 6);
		chk(d >= START_DELAY_CYC && d <= START_DELAY_CYC + 2, 1);
		fork
			pulse(10, 2);
			expo;
		join
		chk(l, 9);
		chk(d, d1);
		// Software command
		fork
			expo;
			apb(1'b1, ADR_SWTRIG, 32'h0000_0001);
		join
		chk(l, 9);
		// Pulse width mode ignores the programmed time
		c = CTRL_RST;
		c.width_mode = 1'b1;
		apb(1'b1, ADR_CTRL, {20'h0, c});
		apb(1'b1, ADR_EXPT, 32'h0000_0003);
		fork
			pulse(10, 4);
			expo;
			begin
				cyc(8);
				apb(1'b0, ADR_STATUS, 32'h0);
			end
		join
		l1 = l;
		chk(rd, 32'h0000_0005);
		fork
			pulse(20, 4);
			expo;
		join
		chk(l - l1, 10);
		// Trigger during readout waits for a line-valid fall
		apb(1'b1, ADR_CTRL, {20'h0, CTRL_RST});
		run <= 1'b1;
		cyc(9);
		fork
			pulse(3, 2);
			expo;
		join
		chk(lv_at, 2'b10);
		run <= 1'b0;
		cyc(2);
		// Debouncer rejects a glitch and a bounce, accepts a held level
		apb(1'b1, ADR_FILT, 32'h0000_0005);
		c = CTRL_RST;
		c.filt_en = 1'b1;
		apb(1'b1, ADR_CTRL, {20'h0, c});
		s0 = starts;
		pulse(3, 20);
		pulse(3, 1);
		pulse(3, 20);
		chk(starts - s0, 0);
		pulse(12, 30);
		chk(starts - s0, 1);
		// Prescaler thinning, clear on write, widest ratio
		c = CTRL_RST;
		c.div_en = 1'b1;
		apb(1'b1, ADR_CTRL, {20'h0, c});
		apb(1'b1, ADR_DIV, 32'h0000_0003);
		s0 = starts;
		repeat (6) pulse(3, 14);
		chk(starts - s0, 2);
		repeat (2) pulse(3, 14);
		apb(1'b1, ADR_DIV, 32'h0000_0003);
		repeat (2) pulse(3, 14);
		chk(starts - s0, 2);
		apb(1'b1, ADR_DIV, 32'hFFFF_FFFF);
		apb(1'b0, ADR_DIV, 32'h0);
		chk(rd, 32'h0000_000F);
		apb(1'b1, ADR_DIV, 32'h0000_0000);
		s0 = starts;
		repeat (16) pulse(3, 14);
		chk(starts - s0, 1);
		// Every Boolean function on lines zero and one
		c = CTRL_RST;
		c.use_logic = 1'b1;
		apb(1'b1, ADR_CTRL, {20'h0, c});
		for (int f = 0; f < 8; f++)
		begin
			apb(1'b1, ADR_FUNC, {29'h0, f[2:0]});
			for (int ab = 0; ab < 4; ab++)
			begin
				trig_lines <= {2'b00, ab[1:0]};
				cyc(3);
				chk(logic_out_q, lexp(f, ab[0], ab[1]));
			end
		end
		trig_lines <= 4'h0;
		// Chained logic operand ports
		c.a_sel = 3'h4;
		c.b_sel = 3'h5;
		apb(1'b1, ADR_CTRL, {20'h0, c});
		apb(1'b1, ADR_FUNC, {29'h0, FN_AND});
		opa <= 1'b1;
		opb <= 1'b1;
		cyc(3);
		chk(logic_out_q, 1);
		opb <= 1'b0;
		cyc(3);
		chk(logic_out_q, 0);
		finish_test;
	end
endmodule
`default_nettype wire
